/* File: src/rrc_regs.vh */
// register indices, field positions, reset values and codes of the block
`ifndef RRC_REGS_VH
`define RRC_REGS_VH
// register index; byte address is four times the index
`define RRC_IDX_DLY        8'h1f
`define RRC_IDX_RET_FIRST  8'h35
`define RRC_IDX_RET_LONG   8'h3a
`define RRC_IDX_RET_LAST   8'h3c
`define RRC_IDX_MRST0      8'h60
`define RRC_IDX_MRST1      8'h61
`define RRC_IDX_MRST2      8'h62
`define RRC_IDX_CHIP       8'h6f
`define RRC_IDX_MODE       8'h70
`define RRC_IDX_STAT       8'h71
// field positions
`define RRC_BIT_CHIP_RST   5
`define RRC_STAT_MODE_LSB  0
`define RRC_STAT_CAUSE_LSB 3
`define RRC_STAT_BUSY_BIT  5
// reset values
`define RRC_RST_RET        8'h00
`define RRC_RST_DLY        8'h10
`define RRC_RST_MRST       8'h00
`define RRC_RST_CHIP       8'h00
// working modes
`define RRC_MODE_ACTIVE    3'h0
`define RRC_MODE_IDLE      3'h1
`define RRC_MODE_SUSPEND   3'h2
`define RRC_MODE_DEEP_RET  3'h3
`define RRC_MODE_DEEP_OFF  3'h4
`define RRC_MODE_SHUTDOWN  3'h5
// last reset cause
`define RRC_CAUSE_POR      2'h0
`define RRC_CAUSE_WDT      2'h1
`define RRC_CAUSE_SW       2'h2
`define RRC_CAUSE_WAKE     2'h3
`endif

/* File: src/rrc_top.v */
// reset sources, retention registers and working-mode power control
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "rrc_regs.vh"
// Functional notes
// - three reset sources: power-on, watchdog, software; watchdog and software clear the same scope
// - power-on reset returns every register, retention ones too, to default
// - retention registers 0x3a..0x3c survive sleep, watchdog and chip reset
// - retention registers 0x35..0x39 survive sleep, cleared by watchdog or chip reset
// - watchdog clears everything except the three long-term retention registers
// - writing one to 0x6f bit 5 resets the chip like a watchdog
// - 0x60..0x62 hold one reset bit per peripheral module
// - six working modes; the power manager unit stays on in all
// - idle and suspend stall the processor while its clock runs
// - main 32 KB SRAM on in active, idle, suspend; off otherwise
// - retention banks kept but closed in deep retention; off deeper
// - deep sleep without retention powers down all but the power manager
// - post-release delay register kept across deep sleep wakeup only
module rrc_top #(
  parameter MRST_W = 24
) (
  input  wire              clk,
  input  wire              rst,
  input  wire              wdt_fire,
  input  wire              wake_pin,
  input  wire [9:0]        wb_adr_i,
  input  wire [31:0]       wb_dat_i,
  input  wire [3:0]        wb_sel_i,
  input  wire              wb_we_i,
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  output reg               sys_rst_out,
  output reg               cpu_stall,
  output reg               cpu_clk_en,
  output reg               power_manager_unit_on,
  output reg               sram_main_pwr,
  output reg               sram_main_acc,
  output reg               sram_ret_pwr,
  output reg               sram_ret_acc,
  output reg               module_pwr,
  output reg  [MRST_W-1:0] module_rst
);

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  wire [7:0] idx;
  wire       req;
  wire       wr;

  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands at the edge where the master sees ack, not before
  assign wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////
  // wake pin synchroniser: a change counts once stages two and three agree

  reg sync1;
  reg sync2;
  reg sync3;
  reg wake_lvl;
  reg wake_evt;

  always @(posedge clk)
  begin
    if (rst)
    begin
      sync1    <= 1'b0;
      sync2    <= 1'b0;
      sync3    <= 1'b0;
      wake_lvl <= 1'b0;
      wake_evt <= 1'b0;
    end
    else
    begin
      sync1    <= wake_pin;
      sync2    <= sync1;
      sync3    <= sync2;
      wake_evt <= 1'b0;
      if (sync2 == sync3)
      begin
        wake_lvl <= sync3;
        wake_evt <= sync3 & ~wake_lvl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset classes

  reg  [7:0] chip_ctl;
  reg  [2:0] mode;
  wire       sw_chip;
  wire       chip_rst;
  wire       deep_mode;
  wire       wake_rst;
  wire       soft_clr;

  // writing the bit back to zero is harmless; only a one fires
  assign sw_chip   = wr & (idx == `RRC_IDX_CHIP)
                     & wb_dat_i[`RRC_BIT_CHIP_RST];
  assign chip_rst  = wdt_fire | sw_chip;
  assign deep_mode = (mode == `RRC_MODE_DEEP_RET)
                     | (mode == `RRC_MODE_DEEP_OFF);
  // deep sleep loses plain digital state, so waking clears it
  assign wake_rst  = deep_mode & wake_evt & ~chip_rst;
  assign soft_clr  = chip_rst | wake_rst;

  ////////////////////////////////////////////////////////////////////////
  // retention registers 0x35..0x3c

  wire [63:0] ret_flat;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_ret
      localparam integer MY_IDX = `RRC_IDX_RET_FIRST + gi;
      reg [7:0] val;
      // long-term entries only follow power-on reset
      wire clr = (MY_IDX >= {24'h000000, `RRC_IDX_RET_LONG})
                 ? 1'b0 : chip_rst;
      always @(posedge clk)
      begin
        if (rst)
          val <= `RRC_RST_RET;
        else if (clr)
          val <= `RRC_RST_RET;
        else if (wr & ({24'h000000, idx} == MY_IDX) & ~chip_rst)
          val <= wb_dat_i[7:0];
      end
      assign ret_flat[gi*8 +: 8] = val;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // delay register, module resets, chip control, mode, cause

  wire [MRST_W-1:0] mrst;

  reg [7:0]        dly_cfg;
  reg [1:0]        cause;
  reg [7:0]        dly_cnt;

  always @(posedge clk)
  begin
    if (rst)
      dly_cfg <= `RRC_RST_DLY;
    else if (chip_rst)
      dly_cfg <= `RRC_RST_DLY;
    else if (wr & (idx == `RRC_IDX_DLY))
      dly_cfg <= wb_dat_i[7:0];
  end

  genvar gm;
  generate
    for (gm = 0; gm < MRST_W / 8; gm = gm + 1)
    begin : g_mrst
      localparam integer MY_IDX = `RRC_IDX_MRST0 + gm;
      reg [7:0] val;
      always @(posedge clk)
      begin
        if (rst | soft_clr)
          val <= `RRC_RST_MRST;
        else if (wr & ({24'h000000, idx} == MY_IDX))
          val <= wb_dat_i[7:0];
      end
      assign mrst[gm*8 +: 8] = val;
    end
  endgenerate

  always @(posedge clk)
  begin
    if (rst | soft_clr)
      chip_ctl <= `RRC_RST_CHIP;
    else if (wr & (idx == `RRC_IDX_CHIP))
      chip_ctl <= wb_dat_i[7:0];
  end

  // mode: software enters a mode from active, the wake pin leaves any but shutdown
  always @(posedge clk)
  begin
    if (rst | soft_clr)
      mode <= `RRC_MODE_ACTIVE;
    else
    begin
      case (mode)
        `RRC_MODE_ACTIVE:
          if (wr & (idx == `RRC_IDX_MODE)
              & (wb_dat_i[2:0] <= `RRC_MODE_SHUTDOWN))
            mode <= wb_dat_i[2:0];
        `RRC_MODE_IDLE,
        `RRC_MODE_SUSPEND:
          if (wake_evt)
            mode <= `RRC_MODE_ACTIVE;
        // deep modes leave through wake_rst; shutdown only through rst or chip_rst
        default:
          mode <= mode;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (rst)
      cause <= `RRC_CAUSE_POR;
    else if (wdt_fire)
      cause <= `RRC_CAUSE_WDT;
    else if (sw_chip)
      cause <= `RRC_CAUSE_SW;
    else if (wake_rst)
      cause <= `RRC_CAUSE_WAKE;
  end

  // post-release delay: loaded from the kept setting after a wake reset, from the default after the others
  always @(posedge clk)
  begin
    if (rst)
      dly_cnt <= `RRC_RST_DLY;
    else if (chip_rst)
      dly_cnt <= `RRC_RST_DLY;
    else if (wake_rst)
      dly_cnt <= dly_cfg;
    else if (dly_cnt != 8'h00)
      dly_cnt <= dly_cnt - 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // power and access outputs

  reg next_stall;
  reg next_clk_en;
  reg next_main_pwr;
  reg next_main_acc;
  reg next_ret_pwr;
  reg next_ret_acc;
  reg next_mod_pwr;

  always @*
  begin
    next_stall    = 1'b0;
    next_clk_en   = 1'b1;
    next_main_pwr = 1'b1;
    next_main_acc = 1'b1;
    next_ret_pwr  = 1'b1;
    next_ret_acc  = 1'b1;
    next_mod_pwr  = 1'b1;
    case (mode)
      `RRC_MODE_ACTIVE:
        next_stall = 1'b0;
      `RRC_MODE_IDLE:
        next_stall = 1'b1;
      `RRC_MODE_SUSPEND:
      begin
        next_stall   = 1'b1;
        next_mod_pwr = 1'b0;
      end
      `RRC_MODE_DEEP_RET:
      begin
        next_stall    = 1'b1;
        next_clk_en   = 1'b0;
        next_main_pwr = 1'b0;
        next_main_acc = 1'b0;
        next_ret_acc  = 1'b0;
        next_mod_pwr  = 1'b0;
      end
      default:
      begin
        next_stall    = 1'b1;
        next_clk_en   = 1'b0;
        next_main_pwr = 1'b0;
        next_main_acc = 1'b0;
        next_ret_pwr  = 1'b0;
        next_ret_acc  = 1'b0;
        next_mod_pwr  = 1'b0;
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      cpu_stall             <= 1'b1;
      cpu_clk_en            <= 1'b1;
      power_manager_unit_on <= 1'b1;
      sram_main_pwr         <= 1'b1;
      sram_main_acc         <= 1'b0;
      sram_ret_pwr          <= 1'b1;
      sram_ret_acc          <= 1'b0;
      module_pwr            <= 1'b1;
      module_rst            <= {MRST_W{1'b1}};
      sys_rst_out           <= 1'b1;
    end
    else
    begin
      // the processor is also held while the system reset delay runs
      cpu_stall             <= next_stall | (dly_cnt != 8'h00);
      cpu_clk_en            <= next_clk_en;
      power_manager_unit_on <= 1'b1;
      sram_main_pwr         <= next_main_pwr;
      sram_main_acc         <= next_main_acc;
      sram_ret_pwr          <= next_ret_pwr;
      sram_ret_acc          <= next_ret_acc;
      module_pwr            <= next_mod_pwr;
      module_rst            <= mrst | {MRST_W{dly_cnt != 8'h00}};
      sys_rst_out           <= (dly_cnt != 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus answer: one wait state, unmapped reads give zero

  reg [7:0] rd_byte;

  always @*
  begin
    rd_byte = 8'h00;
    if ((idx >= `RRC_IDX_RET_FIRST) && (idx <= `RRC_IDX_RET_LAST))
      rd_byte = ret_flat[(idx - `RRC_IDX_RET_FIRST) * 8 +: 8];
    else if (idx == `RRC_IDX_DLY)
      rd_byte = dly_cfg;
    else if ((idx >= `RRC_IDX_MRST0) && (idx <= `RRC_IDX_MRST2))
      rd_byte = mrst[(idx - `RRC_IDX_MRST0) * 8 +: 8];
    else if (idx == `RRC_IDX_CHIP)
      rd_byte = chip_ctl;
    else if (idx == `RRC_IDX_MODE)
      rd_byte = {5'h00, mode};
    else if (idx == `RRC_IDX_STAT)
      rd_byte = {2'h0, (dly_cnt != 8'h00), cause, mode};
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req)
        wb_dat_o <= {24'h000000, rd_byte};
    end
  end

endmodule

/* File: dv/rrc_top_chk.sv */
// port assertions for the reset and retention controller
`timescale 1ns/100ps
module rrc_top_chk #(
  parameter MRST_W = 24
) (
  input wire              clk,
  input wire              rst,
  input wire              wdt_fire,
  input wire              sys_rst_out,
  input wire              cpu_stall,
  input wire              cpu_clk_en,
  input wire              power_manager_unit_on,
  input wire              sram_main_pwr,
  input wire              sram_main_acc,
  input wire              sram_ret_pwr,
  input wire              sram_ret_acc,
  input wire              module_pwr,
  input wire [MRST_W-1:0] module_rst
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  pmu_on_a: assert property (power_manager_unit_on)
    else $error("power manager dropped");
  stall_clk_a: assert property (!cpu_clk_en |-> cpu_stall)
    else $error("clock stopped while processor runs");
  main_acc_a: assert property (sram_main_acc |-> sram_main_pwr)
    else $error("main bank open while unpowered");
  ret_acc_a: assert property (sram_ret_acc |-> sram_ret_pwr)
    else $error("retention bank open while unpowered");
  bank_pair_a: assert property (sram_main_acc |-> sram_ret_acc)
    else $error("retention bank closed beside open main bank");
  // main and module power are off once the clock enable has been low for three cycles
  deep_off_a: assert property ((!cpu_clk_en)[*3] |->
    !sram_main_pwr && !module_pwr) else $error("power left on in deep");
  rst_mod_a: assert property (sys_rst_out |-> &module_rst)
    else $error("module left out of reset");
  rst_stall_a: assert property (sys_rst_out |-> cpu_stall)
    else $error("processor runs during reset");
  por_hold_a: assert property ($fell(rst) |-> sys_rst_out[*8])
    else $error("reset released too early");
  wdt_rst_a: assert property (wdt_fire |-> ##[1:3] sys_rst_out)
    else $error("watchdog did not reset");
  cover property (wdt_fire);
  cover property ((!cpu_clk_en)[*3]);
  cover property (sram_ret_pwr && !sram_ret_acc);
endmodule
bind rrc_top rrc_top_chk #(.MRST_W(MRST_W)) i_rrc_top_chk (
  .clk(clk), .rst(rst), .wdt_fire(wdt_fire), .sys_rst_out(sys_rst_out),
  .cpu_stall(cpu_stall), .cpu_clk_en(cpu_clk_en),
  .power_manager_unit_on(power_manager_unit_on),
  .sram_main_pwr(sram_main_pwr), .sram_main_acc(sram_main_acc),
  .sram_ret_pwr(sram_ret_pwr), .sram_ret_acc(sram_ret_acc),
  .module_pwr(module_pwr), .module_rst(module_rst)
);

/* File: dv/testbench.sv */
// self-checking bench for the reset and retention controller
`timescale 1ns/100ps
`define CHK(n, x, y) \
  check_count++; \
  if ((y) !== (x)) \
  begin \
    err_count++; \
    $display("ERROR %s exp %h got %h", n, x, y); \
  end
module testbench;
  reg         clk = 1'h0;
  reg         rst = 1'h1;
  reg         wdt = 1'h0;
  reg         wake = 1'h0;
  reg         cyc = 1'h0;
  reg         stb = 1'h0;
  reg         we = 1'h0;
  reg  [9:0]  adr = 10'h0;
  reg  [31:0] dat = 32'h0;
  wire [31:0] q;
  wire        ack, sro, stl, cke, pmu, mp, ma, rp, ra, mdp;
  wire [23:0] mrs;
  integer     err_count = 0;
  integer     check_count = 0;
  integer     i;
  reg  [7:0]  e [0:255];
  reg  [7:0]  v, d;
  rrc_top i_rrc_top (
    .clk(clk), .rst(rst), .wdt_fire(wdt), .wake_pin(wake),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h1), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(q), .wb_ack_o(ack),
    .sys_rst_out(sro), .cpu_stall(stl), .cpu_clk_en(cke),
    .power_manager_unit_on(pmu), .sram_main_pwr(mp), .sram_main_acc(ma),
    .sram_ret_pwr(rp), .sram_ret_acc(ra), .module_pwr(mdp),
    .module_rst(mrs)
  );
  initial
  begin
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task bus(input w, input [7:0] a, input [7:0] x);
    begin
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= {a, 2'h0};
      dat <= {24'h0, x};
      do @(posedge clk); while (ack !== 1'h1);
      v = q[7:0];
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
    end
  endtask
  task rdc(input [7:0] a);
    begin
      bus(1'h0, a, 8'h00);
      `CHK("reg", e[a], v)
    end
  endtask
  task wr(input [7:0] a, input [7:0] x);
    begin
      e[a] = x;
      bus(1'h1, a, x);
    end
  endtask
  task ret_all;
    for (i = 8'h35; i <= 8'h3d; i = i + 1)
      rdc(i == 8'h3d ? 8'h1f : i[7:0]);
  endtask
  task fill;
    begin
      for (i = 8'h35; i <= 8'h3c; i = i + 1)
      begin
        d = $urandom;
        wr(i[7:0], d);
      end
      // long delay so a wake reset is still visible after the pin pulse
      d = 8'h20 + $urandom % 16;
      wr(8'h1f, d);
    end
  endtask
  task clr(input por);
    begin
      for (i = 0; i < 256; i = i + 1)
        if (por || i < 8'h3a || i > 8'h3c)
          e[i] = 8'h00;
      e[8'h1f] = 8'h10;
    end
  endtask
  task mset(input z);
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        d = z ? 8'h00 : $urandom;
        wr(8'h60 + i[7:0], d);
      end
      repeat (3) @(posedge clk);
      `CHK("mrst", {e[8'h62], e[8'h61], e[8'h60]}, mrs)
    end
  endtask
  task wait_rel;
    begin
      do @(posedge clk); while (sro !== 1'h1);
      do @(posedge clk); while (sro !== 1'h0);
    end
  endtask
  task pwr(input [2:0] md);
    reg [6:0] x;
    begin
      case (md)
        3'h0: x = 7'h3f;
        3'h1: x = 7'h7f;
        3'h2: x = 7'h7e;
        3'h3: x = 7'h44;
        default: x = 7'h40;
      endcase
      `CHK("pwr", x, {stl, cke, mp, ma, rp, ra, mdp})
      `CHK("pmu", 1'h1, pmu)
    end
  endtask
  task pulse_wake;
    begin
      @(posedge clk);
      wake <= 1'h1;
      repeat (5) @(posedge clk);
      wake <= 1'h0;
      repeat (6) @(posedge clk);
    end
  endtask
  task por;
    begin
      rst <= 1'h1;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      clr(1'h1);
      wait_rel;
    end
  endtask
  task results;
    begin
      if (err_count == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i = $urandom(32'hee1cdbdb);
    por;
    pwr(3'h0);
    fill;
    ret_all;
    bus(1'h1, 8'h40, 8'ha5);
    rdc(8'h40);
    mset(1'h0);
    mset(1'h1);
    mset(1'h0);
    @(posedge clk);
    wdt <= 1'h1;
    @(posedge clk);
    wdt <= 1'h0;
    clr(1'h0);
    wait_rel;
    ret_all;
    `CHK("mrst", 24'h0, mrs)
    bus(1'h0, 8'h71, 8'h00);
    `CHK("stat", 8'h08, v)
    fill;
    wr(8'h6f, 8'h20);
    clr(1'h0);
    wait_rel;
    ret_all;
    bus(1'h0, 8'h71, 8'h00);
    `CHK("stat", 8'h10, v)
    fill;
    // codes above shutdown are refused and leave the mode alone
    bus(1'h1, 8'h70, 8'h06);
    bus(1'h0, 8'h71, 8'h00);
    `CHK("stat", 8'h10, v)
    for (i = 1; i < 6; i = i + 1)
    begin
      wr(8'h70, i[7:0]);
      repeat (4) @(posedge clk);
      pwr(i[2:0]);
      pulse_wake;
      if (i > 2 && i < 5)
        wait_rel;
      pwr(i < 5 ? 3'h0 : 3'h5);
      bus(1'h0, 8'h71, 8'h00);
      `CHK("stat", i < 3 ? 8'h10 : (i < 5 ? 8'h18 : 8'h1d), v)
    end
    ret_all;
    por;
    ret_all;
    results;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    results;
  end
endmodule
